// ### src/bcd_bus_dma.sv
// external bus cycle engine, dma request handshake and apb registers
`timescale 1ns/100ps
`include "bcd_defines.svh"
// Function
// RULE_01: upper byte enable shares A18, qualified by strobe
// RULE_02: byte and odd writes touch one bank
// RULE_03: memory reads ignore A0 and byte enable
// RULE_04: first address phase carries A9..A19 and A0
// RULE_05: fetches whole words, odd keeps high byte
// RULE_06: on-chip ram window runs without waits
// RULE_07: fixed 0,1,2 wait ignores ready input
// RULE_08: asynchronous ready resolves to wait or not
// RULE_09: ready may idle low until cycle end
// RULE_10: request strobe is memory output enable
// RULE_11: memory strobe acts as dram column strobe
// RULE_12: internal accesses keep both strobes high
// RULE_13: write strobe width fixed regardless of waits
// RULE_14: cpu cycle follows dma with no idle; the code passes through one BCD_IDLE clock between them
// RULE_15: io strobe alone times io transfers
// RULE_16: dma acknowledge after 29+N or 27+N clocks
// RULE_17: enable bit clear ignores dma requests
// RULE_18: clearing enable pauses, setting resumes transfer
// RULE_19: dma io transfer drives no io address
// RULE_20: transfer count sets units, 64k bytes/words
// RULE_21: reset clears enable, strobes inactive
module bcd_bus_dma
  import bcd_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ready_i,
  input wire logic dma_request_in_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic upper_byte_enable_n_o,
  output logic memory_request_n_o,
  output logic memory_strobe_n_o,
  output logic io_strobe_n_o,
  output logic write_n_o,
  output logic dma_acknowledge_n_o,
  output logic system_clock_out_o
);

  // software registers
  logic [1:0] wait_control_reg;
  logic [3:0] dma_mode_reg;
  logic [CNT_W-1:0] transfer_count_reg;
  logic [ADDR_W-1:0] dma_addr_reg;
  logic [7:0] instr_clks_reg;
  bcd_cyc_s cpu_cyc_reg;
  logic cpu_pend_reg;
  logic [15:0] rdata_reg;
  logic cpu_done_reg;

  // engine state
  bcd_state_e state_reg;
  bcd_cyc_s cyc_reg;
  logic [1:0] wcnt_reg;
  logic [1:0] stb_cnt_reg;
  logic ready_s1_reg;
  logic ready_s2_reg;
  logic rq_s1_reg;
  logic rq_s2_reg;
  logic rq_seen_reg;
  logic [8:0] lat_reg;
  logic dma_arm_reg;
  logic split_reg;

  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire apb_rd = psel_i & ~penable_i & ~pwrite_i;
  wire dma_en = dma_mode_reg[`BCD_DMA_EN_BIT];
  wire dma_word = dma_mode_reg[`BCD_DMA_WORD_BIT];
  // write strobe countdown start: one clock of delay, then a one clock pulse
  wire [1:0] stb_load = `BCD_WR_STB_CLKS + 2'h1;
  // a write may only finish once its strobe pulse has been issued
  wire stb_issued = ~cyc_reg.wr | (stb_cnt_reg != stb_load);
  wire cyc_internal = ((cyc_reg.addr & `BCD_RAM_MASK) == `BCD_RAM_BASE) & ~cyc_reg.io
                      & ~cyc_reg.dma;
  wire dma_go = dma_arm_reg & (lat_reg == 9'd0) & dma_en & (transfer_count_reg != '0);
  wire [8:0] lat_load = (dma_mode_reg[`BCD_DMA_ONE_BIT] ? {1'b0, `BCD_LAT_ONE}
                        : {1'b0, `BCD_LAT_OTHER}) + {1'b0, instr_clks_reg};

  // apb slave: always one access cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & (paddr_i > `BCD_OFS_DMA_ADDR);
      if (apb_rd) begin
        case (paddr_i)
          `BCD_OFS_WAIT: prdata_o <= {30'h0, wait_control_reg};
          `BCD_OFS_DMA_MODE: prdata_o <= {28'h0, dma_mode_reg};
          `BCD_OFS_COUNT: prdata_o <= 32'(transfer_count_reg);
          `BCD_OFS_CTRL: prdata_o <= {24'h0, instr_clks_reg};
          `BCD_OFS_CPU_ADDR: prdata_o <= 32'(cpu_cyc_reg.addr);
          `BCD_OFS_CPU_RDATA: prdata_o <= {16'h0, rdata_reg};
          `BCD_OFS_STATUS: prdata_o <= {28'h0, dma_arm_reg, ~dma_acknowledge_n_o,
                                         cpu_done_reg, cpu_pend_reg};
          `BCD_OFS_DMA_ADDR: prdata_o <= 32'(dma_addr_reg);
          default: prdata_o <= 32'h0;
        endcase
      end
    end
  end

  // configuration registers, reset leaves dma disabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_control_reg <= 2'h0;
      dma_mode_reg <= 4'h0; // RULE_21
      instr_clks_reg <= 8'h0;
      dma_addr_reg <= '0;
    end else begin
      if (apb_wr && paddr_i == `BCD_OFS_WAIT) wait_control_reg <= pwdata_i[1:0];
      if (apb_wr && paddr_i == `BCD_OFS_DMA_MODE) dma_mode_reg <= pwdata_i[3:0];
      if (apb_wr && paddr_i == `BCD_OFS_CTRL) instr_clks_reg <= pwdata_i[7:0];
      if (apb_wr && paddr_i == `BCD_OFS_DMA_ADDR) begin
        dma_addr_reg <= pwdata_i[ADDR_W-1:0];
      end else if (state_reg == BCD_DONE && cyc_reg.dma) begin
        dma_addr_reg <= dma_addr_reg + (dma_word ? ADDR_W'(2) : ADDR_W'(1));
      end
    end
  end

  // transfer count: one unit per dma cycle, stays put while paused
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      transfer_count_reg <= '0;
    end else if (apb_wr && paddr_i == `BCD_OFS_COUNT) begin
      transfer_count_reg <= pwdata_i[CNT_W-1:0]; // RULE_20
    end else if (state_reg == BCD_DONE && cyc_reg.dma) begin
      transfer_count_reg <= transfer_count_reg - 1'b1; // RULE_20
    end
  end

  // cpu request mailbox; completion flag set wins over clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_cyc_reg <= '0;
      cpu_pend_reg <= 1'b0;
      cpu_done_reg <= 1'b0;
    end else begin
      if (apb_wr && paddr_i == `BCD_OFS_CPU_ADDR) cpu_cyc_reg.addr <= pwdata_i[ADDR_W-1:0];
      if (apb_wr && paddr_i == `BCD_OFS_CPU_WDATA) cpu_cyc_reg.wdata <= pwdata_i[15:0];
      if (apb_wr && paddr_i == `BCD_OFS_CPU_REQ && !cpu_pend_reg) begin
        cpu_cyc_reg.wr <= pwdata_i[`BCD_REQ_WR_BIT];
        cpu_cyc_reg.byte_op <= pwdata_i[`BCD_REQ_BYTE_BIT];
        cpu_cyc_reg.fetch <= pwdata_i[`BCD_REQ_FETCH_BIT];
        cpu_cyc_reg.io <= pwdata_i[`BCD_REQ_IO_BIT];
        cpu_cyc_reg.dma <= 1'b0;
        cpu_pend_reg <= pwdata_i[`BCD_REQ_GO_BIT];
      end else if (state_reg == BCD_IDLE && !dma_go && cpu_pend_reg) begin
        cpu_pend_reg <= 1'b0;
      end
      if (state_reg == BCD_DONE && !cyc_reg.dma && !split_reg) begin
        cpu_done_reg <= 1'b1;
      end else if (apb_wr && paddr_i == `BCD_OFS_STATUS) begin
        cpu_done_reg <= 1'b0;
      end
    end
  end

  // input synchronisers for ready and dma request
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ready_s1_reg <= 1'b0;
      ready_s2_reg <= 1'b0;
      rq_s1_reg <= 1'b0;
      rq_s2_reg <= 1'b0;
    end else begin
      ready_s1_reg <= ready_i; // RULE_08
      ready_s2_reg <= ready_s1_reg;
      rq_s1_reg <= dma_request_in_i;
      rq_s2_reg <= rq_s1_reg;
    end
  end

  // dma request latch and latency counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rq_seen_reg <= 1'b0;
      dma_arm_reg <= 1'b0;
      lat_reg <= 9'd0;
    end else begin
      rq_seen_reg <= rq_s2_reg;
      if (rq_s2_reg && !rq_seen_reg && dma_en && !dma_arm_reg) begin // RULE_17
        dma_arm_reg <= 1'b1;
        lat_reg <= lat_load - 9'd3; // RULE_16
      end else if (dma_arm_reg && lat_reg != 9'd0 && dma_en) begin
        lat_reg <= lat_reg - 9'd1; // paused count holds, RULE_18
      end else if (state_reg == BCD_DONE && cyc_reg.dma) begin
        // unit moved: rearm for next unit unless count ran out or single transfer
        dma_arm_reg <= ~dma_mode_reg[`BCD_DMA_ONE_BIT] & (transfer_count_reg != 1);
      end
    end
  end

  // bus cycle sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= BCD_IDLE;
      cyc_reg <= '0;
      wcnt_reg <= 2'h0;
      stb_cnt_reg <= 2'h0;
      split_reg <= 1'b0;
      rdata_reg <= 16'h0;
    end else begin
      case (state_reg)
        BCD_IDLE: begin
          if (dma_go) begin // RULE_18
            cyc_reg <= '{addr: dma_addr_reg, wdata: 16'h0,
                         wr: dma_mode_reg[`BCD_DMA_DIR_BIT], byte_op: ~dma_word,
                         io: 1'b0, fetch: 1'b0, dma: 1'b1};
            state_reg <= BCD_ADDR;
          end else if (cpu_pend_reg) begin
            cyc_reg <= cpu_cyc_reg;
            // odd word data becomes two byte operations
            split_reg <= cpu_cyc_reg.addr[0] & ~cpu_cyc_reg.byte_op & ~cpu_cyc_reg.fetch; // RULE_02
            if (cpu_cyc_reg.addr[0] & ~cpu_cyc_reg.byte_op & ~cpu_cyc_reg.fetch) begin
              cyc_reg.byte_op <= 1'b1;
            end
            state_reg <= BCD_ADDR;
          end
        end
        BCD_ADDR: begin
          wcnt_reg <= cyc_internal ? 2'h0 : wait_control_reg; // RULE_06
          stb_cnt_reg <= stb_load; // RULE_13
          state_reg <= BCD_DATA;
        end
        BCD_DATA: begin
          if (stb_cnt_reg != 2'h0) stb_cnt_reg <= stb_cnt_reg - 2'h1;
          if (wcnt_reg == `BCD_WAIT_READY) begin
            if (ready_s2_reg && stb_issued) state_reg <= BCD_DONE; // RULE_09
          end else if (wcnt_reg != 2'h0) begin
            wcnt_reg <= wcnt_reg - 2'h1; // RULE_07
          end else if (stb_issued) begin
            state_reg <= BCD_DONE; // RULE_13
          end
        end
        BCD_DONE: begin
          // read data captured as the request strobe rises
          if (!cyc_reg.wr) begin
            if (cyc_reg.fetch && cyc_reg.addr[0]) begin
              rdata_reg <= {8'h0, data_i[15:8]}; // RULE_05
            end else begin
              rdata_reg <= data_i; // RULE_10
            end
          end
          if (split_reg) begin
            split_reg <= 1'b0;
            cyc_reg.addr <= cyc_reg.addr + ADDR_W'(1);
            cyc_reg.wdata <= {8'h0, cyc_reg.wdata[15:8]};
            state_reg <= BCD_ADDR;
          end else begin
            // back to idle for one clock with the bus idle, then the pending cpu cycle starts unless a dma cycle is due
            state_reg <= BCD_IDLE; // RULE_14
          end
        end
        default: state_reg <= BCD_IDLE;
      endcase
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_o <= '0;
      upper_byte_enable_n_o <= 1'b1;
      memory_request_n_o <= 1'b1;
      memory_strobe_n_o <= 1'b1;
      io_strobe_n_o <= 1'b1;
      write_n_o <= 1'b1;
      dma_acknowledge_n_o <= 1'b1; // RULE_21
      data_o <= 16'h0;
      data_oe_o <= 1'b0;
      system_clock_out_o <= 1'b0;
    end else begin
      system_clock_out_o <= ~system_clock_out_o;
      if (state_reg == BCD_IDLE) begin
        memory_request_n_o <= 1'b1;
        memory_strobe_n_o <= 1'b1;
        io_strobe_n_o <= 1'b1;
        write_n_o <= 1'b1;
        data_oe_o <= 1'b0;
        dma_acknowledge_n_o <= 1'b1;
        upper_byte_enable_n_o <= 1'b1;
      end else if (state_reg == BCD_ADDR) begin
        // first phase: high bits and A0 first
        addr_o <= '0;
        addr_o[ADDR_W-1:9] <= cyc_reg.addr[ADDR_W-1:9]; // RULE_04
        addr_o[0] <= cyc_reg.addr[0]; // RULE_04
        dma_acknowledge_n_o <= ~cyc_reg.dma; // RULE_19
      end else if (state_reg == BCD_DATA) begin
        // dma io side gets no address, acknowledge selects it
        addr_o <= cyc_reg.addr;
        write_n_o <= ~cyc_reg.wr;
        data_oe_o <= cyc_reg.wr & ~cyc_internal & ~cyc_reg.dma;
        data_o <= cyc_reg.wdata;
        if (cyc_reg.io) begin
          io_strobe_n_o <= 1'b0; // RULE_15
        end else if (!cyc_internal) begin
          memory_request_n_o <= 1'b0; // RULE_10
          // write strobe fixed width and delayed; reads stretch with waits
          memory_strobe_n_o <= cyc_reg.wr ? (stb_cnt_reg != 2'h1) : 1'b0; // RULE_13 RULE_11
          // byte enable rides on A18 while the strobe is active
          upper_byte_enable_n_o <= ~(~cyc_reg.byte_op | cyc_reg.addr[0]); // RULE_01
          addr_o[18] <= ~(~cyc_reg.byte_op | cyc_reg.addr[0]); // RULE_01
        end else begin
          memory_request_n_o <= 1'b1; // RULE_12
          memory_strobe_n_o <= 1'b1; // RULE_12
        end
      end else begin
        // strobes rise here; reads ignore byte enable
        memory_request_n_o <= 1'b1;
        memory_strobe_n_o <= 1'b1;
        io_strobe_n_o <= 1'b1;
      end
    end
  end

endmodule : bcd_bus_dma

// ### src/bcd_defines.svh
// constants for the external bus cycle and dma handshake block
`ifndef BCD_DEFINES_SVH
`define BCD_DEFINES_SVH
// register byte offsets
`define BCD_OFS_CTRL 12'h000
`define BCD_OFS_WAIT 12'h004
`define BCD_OFS_DMA_MODE 12'h008
`define BCD_OFS_COUNT 12'h00c
`define BCD_OFS_CPU_REQ 12'h010
`define BCD_OFS_CPU_ADDR 12'h014
`define BCD_OFS_CPU_WDATA 12'h018
`define BCD_OFS_CPU_RDATA 12'h01c
`define BCD_OFS_STATUS 12'h020
`define BCD_OFS_DMA_ADDR 12'h024
// field positions
`define BCD_DMA_EN_BIT 0
`define BCD_DMA_WORD_BIT 1
`define BCD_DMA_ONE_BIT 2
`define BCD_DMA_DIR_BIT 3
`define BCD_REQ_GO_BIT 0
`define BCD_REQ_WR_BIT 1
`define BCD_REQ_BYTE_BIT 2
`define BCD_REQ_FETCH_BIT 3
`define BCD_REQ_IO_BIT 4
`define BCD_WAIT_READY 2'h3
// latency figures, clocks
`define BCD_LAT_ONE 8'd29
`define BCD_LAT_OTHER 8'd27
// write strobe fixed width in clocks
`define BCD_WR_STB_CLKS 2'd1
// on-chip ram window, top bits of a 20 bit address
`define BCD_RAM_BASE 20'hffe00
`define BCD_RAM_MASK 20'hffe00
`endif

// ### src/bcd_pkg.sv
// types for the external bus cycle and dma handshake block
package bcd_pkg;
  typedef enum logic [2:0] {
    BCD_IDLE, BCD_ADDR, BCD_DATA, BCD_WAIT, BCD_DONE
  } bcd_state_e;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic byte_op;
    logic io;
    logic fetch;
    logic dma;
  } bcd_cyc_s;
endpackage : bcd_pkg

// ### tb/bcd_assertions.sv
// port checker for the bus cycle and dma handshake block
`timescale 1ns/100ps
module bcd_assertions
  import bcd_pkg::*;
#(parameter int ADDR_W = 20, parameter int CNT_W = 16) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic dma_request_in_i,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic upper_byte_enable_n_o,
  input wire logic memory_request_n_o,
  input wire logic memory_strobe_n_o,
  input wire logic io_strobe_n_o,
  input wire logic write_n_o,
  input wire logic dma_acknowledge_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] since_rq_reg;
  // clocks since the last request edge, saturating so old requests stay old
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) since_rq_reg <= 8'hff;
    else if ($rose(dma_request_in_i)) since_rq_reg <= 8'h00;
    else if (since_rq_reg != 8'hff) since_rq_reg <= since_rq_reg + 8'h01;
  end
  property p_rst_idle;
    $rose(rst_n_i) |-> memory_request_n_o && memory_strobe_n_o && io_strobe_n_o
      && dma_acknowledge_n_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("strobe active after reset");
  property p_rdy;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy_acc;
    pready_o |-> psel_i && penable_i;
  endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
  property p_err;
    pready_o && paddr_i > 12'h024 |-> pslverr_o;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ube;
    !memory_strobe_n_o |-> addr_o[18] == upper_byte_enable_n_o;
  endproperty
  a_ube: assert property (p_ube) else $error("byte enable not on A18");
  property p_ram;
    !memory_request_n_o |-> !(addr_o[19] && &addr_o[17:9]);
  endproperty
  a_ram: assert property (p_ram) else $error("strobe on on-chip ram");
  property p_excl;
    !(!io_strobe_n_o && !memory_strobe_n_o);
  endproperty
  a_excl: assert property (p_excl) else $error("io and memory strobe overlap");
  // write strobe is a single clock pulse whatever the wait count
  property p_wstb;
    !memory_strobe_n_o && !write_n_o |=> memory_strobe_n_o;
  endproperty
  a_wstb: assert property (p_wstb) else $error("write strobe wider than one clock");
  property p_lat;
    $fell(dma_acknowledge_n_o) |-> since_rq_reg >= 8'd27;
  endproperty
  a_lat: assert property (p_lat) else $error("acknowledge too early");
  c_ack: cover property ($fell(dma_acknowledge_n_o));
  c_err: cover property (pready_o && pslverr_o);
  c_ube: cover property (!memory_strobe_n_o && !upper_byte_enable_n_o);
endmodule : bcd_assertions
bind bcd_bus_dma bcd_assertions #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (.clk_i, .rst_n_i,
  .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .dma_request_in_i, .addr_o,
  .upper_byte_enable_n_o, .memory_request_n_o, .memory_strobe_n_o, .io_strobe_n_o,
  .write_n_o, .dma_acknowledge_n_o);

// ### tb/bcd_mem_model.sv
// external memory and io partner of the bus cycle block
`timescale 1ns/100ps
module bcd_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [19:0] addr_i,
  input wire logic memory_request_n_n_i,
  input wire logic io_strobe_n_n_i,
  input wire logic [3:0] dly_i,
  output logic [15:0] data_o,
  output logic ready_o
);
  logic [3:0] cnt_reg;
  logic [15:0] last_reg;
  // strobe-low cycle count sets how slow the device answers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || (memory_request_n_n_i && io_strobe_n_n_i)) cnt_reg <= 4'h0;
    else if (cnt_reg != 4'hf) cnt_reg <= cnt_reg + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) last_reg <= 16'h0000;
    else if (!memory_request_n_n_i) last_reg <= data_o;
  end
  assign ready_o = cnt_reg >= dly_i;
  // full word whatever A0 says; released bus shows the inverse
  assign data_o = !memory_request_n_n_i ? {~addr_i[8:1], addr_i[8:1]} : ~last_reg;
endmodule : bcd_mem_model

// ### tb/tb_bus_cycle_and_dma_handshake.sv
// random and corner-case bench for the bus cycle and dma block
`timescale 1ns/100ps
module tb_bus_cycle_and_dma_handshake;
  import bcd_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ready, dreq, data_oe, ube_n;
  logic memory_request_n_n, memory_strobe_n_n, io_strobe_n_n, wr_n, ack_n, clk_out, lerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] din, dout, e;
  logic [19:0] addr, a;
  logic [3:0] dly;
  int num_errors, n_checks, seed, k, n;
  bcd_bus_dma #(.ADDR_W(20), .CNT_W(16)) uut (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ready_i(ready),
    .dma_request_in_i(dreq), .data_i(din), .data_o(dout), .data_oe_o(data_oe),
    .addr_o(addr), .upper_byte_enable_n_o(ube_n), .memory_request_n_o(memory_request_n_n),
    .memory_strobe_n_o(memory_strobe_n_n), .io_strobe_n_o(io_strobe_n_n), .write_n_o(wr_n),
    .dma_acknowledge_n_o(ack_n), .system_clock_out_o(clk_out));
  bcd_mem_model mem (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .memory_request_n_n_i(memory_request_n_n),
    .io_strobe_n_n_i(io_strobe_n_n), .dly_i(dly), .data_o(din), .ready_o(ready));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] pat(input logic [19:0] x);
    return {~x[8:1], x[8:1]};
  endfunction : pat
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, request held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // launch a cpu cycle, poll done within lim reads, fetch the data
  task automatic cpu(input logic [19:0] x, input logic [31:0] q, input int lim);
    int i;
    apb(1'b1, 12'h014, {12'h000, x});
    apb(1'b1, 12'h010, q);
    i = 0;
    do begin
      apb(1'b0, 12'h020, 32'h0);
      i++;
    end while (r[1] !== 1'b1 && i < lim);
    chk({31'h0, r[1]}, 32'h1);
    apb(1'b1, 12'h020, 32'h2);
    apb(1'b0, 12'h01c, 32'h0);
  endtask : cpu
  task automatic ackwait(input int lim);
    k = 0;
    while (ack_n !== 1'b0 && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask : ackwait
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // watchdog well beyond the several hundred cycles the run needs
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {psel, penable, pwrite, dreq, rst_n} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dly = 4'h0;
    seed = 29477;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h008, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 12'h028, 32'h0);
    chk({r[30:0], lerr}, 32'h1);
    apb(1'b1, 12'h00c, 32'hffff);
    apb(1'b0, 12'h00c, 32'h0);
    chk(r, 32'hffff);
    // fixed waits get a ready that would stall them; mode 3 a random delay
    for (int m = 0; m < 4; m++) begin
      n = $random(seed);
      a = {1'b0, n[18:1], 1'b0};
      dly <= (m == 3) ? {2'b00, n[20:19]} : 4'hf;
      apb(1'b1, 12'h004, m);
      cpu(a, 32'h1, (m == 3) ? 20 : 4);
      chk({16'h0, r[15:0]}, {16'h0, pat(a)});
    end
    a = a | 20'h1;
    e = pat(a);
    cpu(a, 32'h9, 20);
    chk({24'h0, r[7:0]}, {24'h0, e[15:8]});
    dly <= 4'hf;
    cpu(20'hffe10, 32'h1, 3);
    dly <= 4'h1;
    cpu(a, 32'h3, 20);
    cpu(a, 32'h13, 20);
    apb(1'b1, 12'h024, 32'h100);
    // one-transfer then other mode, random instruction length
    for (int m = 0; m < 2; m++) begin
      n = $random(seed) & 7;
      apb(1'b1, 12'h00c, 32'h2);
      apb(1'b1, 12'h000, n);
      apb(1'b1, 12'h008, m ? 32'h1 : 32'h5);
      dreq <= 1'b1;
      ackwait(200);
      chk({31'h0, k >= (m ? 27 : 29) + n && k < 200}, 32'h1);
      dreq <= 1'b0;
      repeat (40) @(posedge clk);
    end
    apb(1'b1, 12'h008, 32'h0);
    dreq <= 1'b1;
    ackwait(80);
    chk({31'h0, ack_n}, 32'h1);
    dreq <= 1'b0;
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b1, 12'h008, 32'h1);
    dreq <= 1'b1;
    repeat (5) @(posedge clk);
    apb(1'b1, 12'h008, 32'h0);
    ackwait(80);
    chk({31'h0, ack_n}, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    ackwait(100);
    chk({31'h0, ack_n}, 32'h0);
    dreq <= 1'b0;
    repeat (40) @(posedge clk);
    print_verdict();
  end
endmodule : tb_bus_cycle_and_dma_handshake
